//--- common/lcgk_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef LCGK_MAP_SVH
`define LCGK_MAP_SVH

// Per-channel register word offsets; channel n sits at n * LCGK_CH_STRIDE.
`define LCGK_CH_STRIDE       12'h040
`define LCGK_OFS_LOOP_COEF   4'h0
`define LCGK_OFS_OFFHK_TH    4'h1
`define LCGK_OFS_ONHK_TH     4'h2
`define LCGK_OFS_LOOP_DBI    4'h3
`define LCGK_OFS_MASK_TIME   4'h4
`define LCGK_OFS_GK_COEF     4'h5
`define LCGK_OFS_GK_SET_TH   4'h6
`define LCGK_OFS_GK_REL_TH   4'h7
`define LCGK_OFS_GK_DBI      4'h8
`define LCGK_OFS_CM_TH       4'h9
`define LCGK_OFS_LINEFEED    4'ha
`define LCGK_OFS_HOOK_STAT   4'hb
`define LCGK_OFS_LOOP_CUR    4'hc
`define LCGK_OFS_LONG_CUR    4'hd
`define LCGK_OFS_IRQ_PEND    4'he
`define LCGK_OFS_IRQ_EN      4'hf
`define LCGK_NUM_CFG         10

// Status and interrupt bit positions.
`define LCGK_BIT_LOOP        0
`define LCGK_BIT_GKEY        1
`define LCGK_BIT_CM_HIGH     2

// Reset values.
`define LCGK_RST_COEF        16'h4000
`define LCGK_RST_TH          16'h0000
`define LCGK_RST_LF          3'h0

// Filter gain: 4000h is unity, coefficient bits 2:0 are ignored.
`define LCGK_COEF_UNITY      16'h4000
`define LCGK_COEF_SHIFT      14

// Threshold limits in sense LSBs of 3.097 uA: 61 mA loop, 16 mA ground key.
`define LCGK_LOOP_TH_MAX     16'h4cf0
`define LCGK_GK_TH_MAX       16'h142e

// Detector step of 1.25 ms at a 25 ns clock.
`define LCGK_STEP_NS         1250000
`define LCGK_CLK_NS          25
`define LCGK_STEP_CYCLES     (`LCGK_STEP_NS / `LCGK_CLK_NS)

`endif

//--- common/lcgk_pkg.sv
// Types shared by the loop-closure and ground-key detector.
package lcgk_pkg;

  typedef enum logic [2:0] {
    LF_FWD_ACTIVE = 3'h1,
    LF_TIP_OPEN   = 3'h3,
    LF_REV_ACTIVE = 3'h5,
    LF_RING_OPEN  = 3'h7
  } lcgk_lf_e;

  typedef struct packed {
    logic signed [15:0] iq1;
    logic signed [15:0] iq2;
    logic signed [15:0] iq5;
    logic signed [15:0] iq6;
    logic        [15:0] cm;
  } lcgk_sense_s;

  typedef struct packed {
    logic cm_high;
    logic gkey;
    logic offhook;
  } lcgk_stat_s;

endpackage

//--- design/lcgk_detect.sv
// Two-channel loop-closure and ground-key detector with AXI4-Lite registers.
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Loop current is Q1-Q6+Q5-Q2, halved except in tip-open and ring-open.
// - Common-mode high in linefeed states 1 or 3 zeroes the Q1 term.
// - Common-mode high in linefeed states 5 or 7 zeroes the Q2 term.
// - Common-mode flag is set while sensed value exceeds its threshold.
// - Loop current passes a low-pass filter; 0h blocks, 4000h passes.
// - Off-hook threshold sets, separate on-hook threshold releases, hysteresis.
// - A loop threshold above 61 mA disables loop detection.
// - Loop comparator is debounced over a 16-bit interval of 1.25 ms steps.
// - A 16-bit mask interval hides transients after a ringing burst ends.
// - Debounced result drives the read-only off-hook status bit.
// - Loop closure event sets a pending bit gated by an enable bit.
// - Longitudinal current Q1-Q6-Q5+Q2 halved, only in tip- or ring-open.
// - Longitudinal current has its own low-pass filter, same coefficient rule.
// - Ground-key set threshold with a release threshold for hysteresis.
// - Ground-key comparator has its own debounce, driving the status bit.
// - Off-hook rising moves tip-open to forward, ring-open to reverse active.
// - Shadow codes tip-open as 3 and forward-active as 1.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "lcgk_map.svh"

module lcgk_detect #(
  parameter int NCH        = 2,
  parameter int STEP_CYCLS = `LCGK_STEP_CYCLES
) (
  input  wire logic                   aclk,       // 40 MHz clock
  input  wire logic                   aresetn,    // Synchronous reset
  input  wire logic [11:0]            awaddr,     // Write address
  input  wire logic                   awvalid,    // Write address valid
  output logic                        awready,    // Write address ready
  input  wire logic [31:0]            wdata,      // Write data
  input  wire logic [3:0]             wstrb,      // Write byte enables
  input  wire logic                   wvalid,     // Write data valid
  output logic                        wready,     // Write data ready
  output logic [1:0]                  bresp,      // Write response
  output logic                        bvalid,     // Write response valid
  input  wire logic                   bready,     // Write response ready
  input  wire logic [11:0]            araddr,     // Read address
  input  wire logic                   arvalid,    // Read address valid
  output logic                        arready,    // Read address ready
  output logic [31:0]                 rdata,      // Read data
  output logic [1:0]                  rresp,      // Read response
  output logic                        rvalid,     // Read data valid
  input  wire logic                   rready,     // Read data ready
  input  wire lcgk_pkg::lcgk_sense_s  sense [NCH], // Linefeed current sense
  input  wire logic [NCH-1:0]         ring_active, // Ringing burst, no offset
  output logic [NCH-1:0][2:0]         linefeed_state_shadow, // Linefeed state
  output lcgk_pkg::lcgk_stat_s        status [NCH], // Hook status per channel
  output logic                        irq          // Enabled pending events
);

  // ****************************************************************
  // Detector step timer
  // ****************************************************************
  // One shared tick paces both channels, so a new timer setting takes
  // effect with up to one tick of extra delay.
  logic [31:0] step_cnt_q;
  wire         step = (step_cnt_q == 32'(STEP_CYCLS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || step) begin
      step_cnt_q <= 32'h0;
    end else begin
      step_cnt_q <= step_cnt_q + 32'h1;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_have_q, w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] rdata_q;
  logic        rerr_q, berr_q;
  logic        bvalid_q, rvalid_q;
  logic [31:0] rd_word [NCH];
  logic [NCH-1:0] irq_ch;

  // Address and data may come in either order; both are held until the
  // response is taken, so at most one write and one read are ever open.
  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid  = bvalid_q;
  assign rvalid  = rvalid_q;
  assign bresp   = berr_q ? 2'h2 : 2'h0;
  assign rresp   = rerr_q ? 2'h2 : 2'h0;
  assign rdata   = rdata_q;
  assign irq     = |irq_ch;

  wire         wr_go    = aw_have_q && w_have_q && !bvalid_q;
  wire         wr_hit   = (awaddr_q[11:7] == 5'h0);
  wire         rd_hit   = (araddr[11:7] == 5'h0);
  wire         rd_take  = arvalid && !rvalid_q;
  wire  [3:0]  wr_idx   = awaddr_q[5:2];
  wire  [3:0]  rd_idx   = araddr[5:2];
  wire         wr_ch    = awaddr_q[6];
  wire         rd_ch    = araddr[6];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      berr_q    <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        berr_q    <= !wr_hit;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rerr_q   <= 1'b0;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_hit ? rd_word[rd_ch] : 32'h0;
      rerr_q   <= !rd_hit;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Byte-lane merge of the low half word, used by every 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old);
    merge16 = {wstrb_q[1] ? wdata_q[15:8] : old[15:8],
               wstrb_q[0] ? wdata_q[7:0]  : old[7:0]};
  endfunction

  // First-order low-pass step: y += (x - y) * coef / 4000h.
  // A coefficient above unity is clamped so that a step never overshoots.
  function automatic logic signed [15:0] lpf(
    input logic signed [15:0] y,
    input logic signed [15:0] x,
    input logic        [15:0] coef_raw
  );
    logic        [15:0] coef;
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    coef = (coef_raw > `LCGK_COEF_UNITY) ? `LCGK_COEF_UNITY
                                         : {coef_raw[15:3], 3'h0};
    diff = 17'(x) - 17'(y);
    prod = diff * $signed({1'b0, coef});
    lpf  = 16'(y + 16'(prod >>> `LCGK_COEF_SHIFT));
  endfunction

  // ****************************************************************
  // Per-channel detection chains
  // ****************************************************************
  // Each channel keeps its own chain; only the tick and the bus are shared.
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [15:0] cfg_q [`LCGK_NUM_CFG];
    logic [2:0]  lf_q;
    logic [1:0]  pend_q, en_q;
    lcgk_pkg::lcgk_sense_s s_meta_q, s_q;
    logic        ring_meta_q, ring_q, ring_d1_q;
    logic signed [15:0] loop_f_q, long_f_q;
    logic        off_q, gk_q, off_d1_q, gk_d1_q;
    logic [16:0] ldb_q, gdb_q;
    logic [15:0] mask_q;

    // Sense values come from the analog side and are resynchronised.
    // A word caught while it changes may tear for one clock; a debounce
    // setting above one tick rides through such a sample.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s_meta_q    <= '0;
        s_q         <= '0;
        ring_meta_q <= 1'b0;
        ring_q      <= 1'b0;
        ring_d1_q   <= 1'b0;
      end else begin
        s_meta_q    <= sense[c];
        s_q         <= s_meta_q;
        ring_meta_q <= ring_active[c];
        ring_q      <= ring_meta_q;
        ring_d1_q   <= ring_q;
      end
    end

    // The flag is registered so that the status output comes from a
    // flip-flop; the loop conditioning sees it one clock later, which is
    // far inside one detector tick.
    logic cm_high_q;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cm_high_q <= 1'b0;
      end else begin
        cm_high_q <= (s_q.cm > cfg_q[`LCGK_OFS_CM_TH]);
      end
    end

    wire st_open  = (lf_q == lcgk_pkg::LF_TIP_OPEN) ||
                    (lf_q == lcgk_pkg::LF_RING_OPEN);
    wire zero_q1  = cm_high_q && ((lf_q == lcgk_pkg::LF_FWD_ACTIVE) ||
                                  (lf_q == lcgk_pkg::LF_TIP_OPEN));
    wire zero_q2  = cm_high_q && ((lf_q == lcgk_pkg::LF_REV_ACTIVE) ||
                                  (lf_q == lcgk_pkg::LF_RING_OPEN));
    wire signed [17:0] t_q1 = zero_q1 ? 18'sh0 : 18'(s_q.iq1);
    wire signed [17:0] t_q2 = zero_q2 ? 18'sh0 : 18'(s_q.iq2);
    wire signed [17:0] t_q5 = 18'(s_q.iq5);
    wire signed [17:0] t_q6 = 18'(s_q.iq6);
    wire signed [17:0] loop_sum = t_q1 - t_q6 + t_q5 - t_q2;
    wire signed [17:0] loop_raw = st_open ? loop_sum
                                          : (loop_sum >>> 1);
    wire signed [17:0] long_sum = 18'(s_q.iq1) - t_q6 - t_q5
                                  + 18'(s_q.iq2);
    wire signed [17:0] long_raw = st_open ? (long_sum >>> 1)
                                          : 18'sh0;

    // Saturate to the 16-bit sense range before filtering. Both sums can
    // reach 18 bits, and a wrap would flip the sign and fake a detection.
    wire signed [15:0] loop_in =
      (loop_raw > 18'sh07fff) ? 16'sh7fff :
      (loop_raw < -18'sh08000) ? -16'sh8000 : 16'(loop_raw);
    wire signed [15:0] long_in =
      (long_raw > 18'sh07fff) ? 16'sh7fff :
      (long_raw < -18'sh08000) ? -16'sh8000 : 16'(long_raw);

    // Compare magnitudes so that reverse polarity detects alike.
    wire [15:0] loop_mag = loop_f_q[15] ? 16'(-loop_f_q) : loop_f_q;
    wire [15:0] long_mag = long_f_q[15] ? 16'(-long_f_q) : long_f_q;

    wire loop_en = (cfg_q[`LCGK_OFS_OFFHK_TH] <= `LCGK_LOOP_TH_MAX) &&
                   (cfg_q[`LCGK_OFS_ONHK_TH] <= `LCGK_LOOP_TH_MAX);
    wire gk_en   = (cfg_q[`LCGK_OFS_GK_SET_TH] <= `LCGK_GK_TH_MAX) &&
                   (cfg_q[`LCGK_OFS_GK_REL_TH] <= `LCGK_GK_TH_MAX);
    wire loop_cmp = off_q ? (loop_mag >= cfg_q[`LCGK_OFS_ONHK_TH])
                          : (loop_mag > cfg_q[`LCGK_OFS_OFFHK_TH]);
    wire gk_cmp   = gk_q ? (long_mag >= cfg_q[`LCGK_OFS_GK_REL_TH])
                         : (long_mag > cfg_q[`LCGK_OFS_GK_SET_TH]);
    wire masked   = (mask_q != 16'h0);
    wire loop_in_st = loop_en && loop_cmp && !masked;
    wire gk_in_st   = gk_en && gk_cmp;
    wire [16:0] ldb_n = ldb_q + 17'h1;
    wire [16:0] gdb_n = gdb_q + 17'h1;

    // Mask hides the loop chain after a burst ends; the debounce count
    // restarts meanwhile so a ringing tail cannot build toward closure.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mask_q <= 16'h0;
      end else if (!ring_q && ring_d1_q) begin
        mask_q <= cfg_q[`LCGK_OFS_MASK_TIME];
      end else if (step && masked) begin
        mask_q <= mask_q - 16'h1;
      end
    end

    // A debounce setting of 0 acts like 1: a flag follows on the first
    // tick that disagrees with it, never sooner.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        loop_f_q <= 16'sh0;
        long_f_q <= 16'sh0;
        off_q    <= 1'b0;
        gk_q     <= 1'b0;
        ldb_q    <= 17'h0;
        gdb_q    <= 17'h0;
      end else if (step) begin
        loop_f_q <= lpf(loop_f_q, loop_in,
                        cfg_q[`LCGK_OFS_LOOP_COEF]);
        long_f_q <= lpf(long_f_q, long_in,
                        cfg_q[`LCGK_OFS_GK_COEF]);
        if (loop_in_st == off_q || masked) begin
          ldb_q <= 17'h0;
        end else if (ldb_n >= 17'(cfg_q[`LCGK_OFS_LOOP_DBI])) begin
          off_q <= loop_in_st;
          ldb_q <= 17'h0;
        end else begin
          ldb_q <= ldb_n;
        end
        if (gk_in_st == gk_q) begin
          gdb_q <= 17'h0;
        end else if (gdb_n >= 17'(cfg_q[`LCGK_OFS_GK_DBI])) begin
          gk_q  <= gk_in_st;
          gdb_q <= 17'h0;
        end else begin
          gdb_q <= gdb_n;
        end
      end
    end

    // ****************************************************************
    // Per-channel registers and events
    // ****************************************************************
    // Register writes, linefeed auto transition and sticky events.
    wire wr_me   = wr_go && wr_hit && (wr_ch == 1'(c));
    wire off_up  = off_q && !off_d1_q;
    wire [1:0] ev = {gk_q != gk_d1_q, off_q != off_d1_q};

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        for (int i = 0; i < `LCGK_NUM_CFG; i++) begin
          cfg_q[i] <= (i == `LCGK_OFS_LOOP_COEF || i == `LCGK_OFS_GK_COEF)
                      ? `LCGK_RST_COEF : `LCGK_RST_TH;
        end
        lf_q     <= `LCGK_RST_LF;
        pend_q   <= 2'h0;
        en_q     <= 2'h0;
        off_d1_q <= 1'b0;
        gk_d1_q  <= 1'b0;
      end else begin
        off_d1_q <= off_q;
        gk_d1_q  <= gk_q;
        if (wr_me && wr_idx < 4'(`LCGK_NUM_CFG)) begin
          cfg_q[wr_idx] <= merge16(cfg_q[wr_idx]);
        end
        if (wr_me && wr_idx == `LCGK_OFS_IRQ_EN && wstrb_q[0]) begin
          en_q <= wdata_q[1:0];
        end
        // Set wins over a write-one clear in the same cycle.
        pend_q <= (wr_me && wr_idx == `LCGK_OFS_IRQ_PEND && wstrb_q[0])
                  ? ((pend_q & ~wdata_q[1:0]) | ev) : (pend_q | ev);
        // Only off-hook drives the automatic move, never the ground key.
        if (off_up && lf_q == lcgk_pkg::LF_TIP_OPEN) begin
          lf_q <= lcgk_pkg::LF_FWD_ACTIVE;
        end else if (off_up && lf_q == lcgk_pkg::LF_RING_OPEN) begin
          lf_q <= lcgk_pkg::LF_REV_ACTIVE;
        end else if (wr_me && wr_idx == `LCGK_OFS_LINEFEED && wstrb_q[0]) begin
          lf_q <= wdata_q[2:0];
        end
      end
    end

    assign irq_ch[c] = |(pend_q & en_q);
    assign linefeed_state_shadow[c] = lf_q;
    assign status[c] = '{cm_high: cm_high_q, gkey: gk_q,
                         offhook: off_q};

    // ****************************************************************
    // Per-channel read-back
    // ****************************************************************
    // Status and currents are read live, so two reads of one word may
    // differ by a detector tick.
    wire [15:0] stat16 = {13'h0, cm_high_q, gk_q, off_q};
    wire [15:0] rd16 =
      (rd_idx < 4'(`LCGK_NUM_CFG))   ? cfg_q[rd_idx] :
      (rd_idx == `LCGK_OFS_LINEFEED) ? {13'h0, lf_q} :
      (rd_idx == `LCGK_OFS_HOOK_STAT) ? stat16 :
      (rd_idx == `LCGK_OFS_LOOP_CUR) ? loop_f_q :
      (rd_idx == `LCGK_OFS_LONG_CUR) ? long_f_q :
      (rd_idx == `LCGK_OFS_IRQ_PEND) ? {14'h0, pend_q} : {14'h0, en_q};
    assign rd_word[c] = {16'h0, rd16};
  end

endmodule

//--- sim/lcgk_detect_assertions.sv
// Checker bound to the detector top: bus handshakes and hook flags.
`timescale 1ns/100ps
module lcgk_detect_assertions #(
  parameter int NCH = 2
) (
  input wire logic                 aclk,                  // Clock
  input wire logic                 aresetn,               // Reset, low
  input wire logic [11:0]          awaddr,                // Write address
  input wire logic                 awvalid,               // Aw valid
  input wire logic                 awready,               // Aw ready
  input wire logic                 wvalid,                // W valid
  input wire logic                 wready,                // W ready
  input wire logic [1:0]           bresp,                 // Write response
  input wire logic                 bvalid,                // B valid
  input wire logic [11:0]          araddr,                // Read address
  input wire logic                 arvalid,               // Ar valid
  input wire logic                 arready,               // Ar ready
  input wire logic [1:0]           rresp,                 // Read response
  input wire logic                 rvalid,                // R valid
  input wire logic [NCH-1:0][2:0]  linefeed_state_shadow, // Shadow
  input wire lcgk_pkg::lcgk_stat_s status [NCH]           // Status
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************************************
  // Register bus
  // ****************************************************************
  property p_wr_resp;
    awvalid && awready && wvalid && wready |-> ##2
      bvalid && bresp == ($past(awaddr, 2) >= 12'h080 ? 2'h2 : 2'h0);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("bad write response");
  property p_b_block; bvalid |-> !awready && !wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken early");
  property p_rd_resp;
    arvalid && arready |=>
      rvalid && rresp == ($past(araddr) >= 12'h080 ? 2'h2 : 2'h0);
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("bad read response");
  property p_ar_rdy; rvalid |-> !arready; endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("second read taken");
  // ****************************************************************
  // Hook detection
  // ****************************************************************
  // Two cycles of slack cover the register stage behind the status flag.
  property p_auto_lf;
    $rose(status[0].offhook) |-> ##[0:2]
      (linefeed_state_shadow[0] != 3'h3 && linefeed_state_shadow[0] != 3'h7);
  endproperty
  a_auto_lf: assert property (p_auto_lf)
    else $error("no auto linefeed");
  property p_auto_lf1;
    $rose(status[1].offhook) |-> ##[0:2]
      (linefeed_state_shadow[1] != 3'h3 && linefeed_state_shadow[1] != 3'h7);
  endproperty
  a_auto_lf1: assert property (p_auto_lf1)
    else $error("no auto lf one");
  property p_gk_only;
    $rose(status[0].gkey) && !status[0].offhook &&
      linefeed_state_shadow[0] == 3'h3 |=> linefeed_state_shadow[0] == 3'h3;
  endproperty
  a_gk_only: assert property (p_gk_only)
    else $error("ground key moved lf");
  property p_db_min; $rose(status[0].offhook) |=> status[0].offhook [*8];
  endproperty
  a_db_min: assert property (p_db_min)
    else $error("hook flag glitch");
endmodule

bind lcgk_detect lcgk_detect_assertions #(.NCH(NCH)) u_lcgk_detect_assertions (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rresp(rresp), .rvalid(rvalid),
  .linefeed_state_shadow(linefeed_state_shadow), .status(status));

//--- sim/lcgk_line_model.sv
// Line sense model: transistor currents and ringing state of one line.
`timescale 1ns/100ps
module lcgk_line_model (
  input  wire logic                  aclk,       // Clock
  input  wire lcgk_pkg::lcgk_sense_s want,       // Line condition to show
  input  wire logic                  ring_in,    // Ringing burst request
  output lcgk_pkg::lcgk_sense_s      sense,      // Sensed currents
  output logic                       ring_active // Ringing burst, no offset
);
  // A register stage stands in for sense settling time; the sense lines
  // are never released, so they always carry a real current value.
  always_ff @(posedge aclk) begin
    sense <= want;
    ring_active <= ring_in;
  end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the two-channel hook and ground-key detector.
`timescale 1ns/100ps
module testbench;
  localparam int STEP = 20;
  localparam int Q1 = 100, Q2 = 10, Q5 = 60, Q6 = 20;
  logic                       aclk = 1'b0, aresetn = 1'b0;
  logic                       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                       arvalid = 1'b0, rready = 1'b0;
  logic [11:0]                awaddr = '0, araddr = '0;
  logic [31:0]                wdata = '0;
  logic [3:0]                 wstrb = '0;
  logic [1:0]                 ring = '0;
  lcgk_pkg::lcgk_sense_s      want [2] = '{default: '0};
  int                         n_fail = 0, comparisons = 0;
  wire                        awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0]                  bresp, rresp, ring_act;
  wire [31:0]                 rdata;
  wire [1:0][2:0]             shadow;
  wire lcgk_pkg::lcgk_sense_s sense [2];
  wire lcgk_pkg::lcgk_stat_s  status [2];

  always #12.5 aclk = ~aclk;

  lcgk_detect #(.NCH(2), .STEP_CYCLS(STEP)) u_lcgk_detect (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sense(sense),
    .ring_active(ring_act), .linefeed_state_shadow(shadow),
    .status(status), .irq(irq));
  for (genvar i = 0; i < 2; i++) begin : g_line
    lcgk_line_model u_lcgk_line_model (.aclk(aclk), .want(want[i]),
      .ring_in(ring[i]), .sense(sense[i]), .ring_active(ring_act[i]));
  end

  // ****************************************************************
  // Bus tasks and expectations
  // ****************************************************************
  function automatic logic [11:0] ad(input int ch, input int ix);
    return 12'(ch * 64 + ix * 4);
  endfunction
  function automatic lcgk_pkg::lcgk_sense_s sv(input int q1, q2, q5, q6, cm);
    return '{16'(q1), 16'(q2), 16'(q5), 16'(q6), 16'(cm)};
  endfunction
  function automatic int eloop(input int lf, input int c);
    int v;
    v = (c && lf < 4 ? 0 : Q1) - Q6 + Q5 - (c && lf > 4 ? 0 : Q2);
    return (lf == 3 || lf == 7) ? v : v / 2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, a >= 12'h080 ? 2'h2 : 2'h0);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, a >= 12'h080 ? 32'h0 : e);
    chk(rresp, a >= 12'h080 ? 2'h2 : 2'h0);
    @(posedge aclk);
  endtask
  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ad(0, 0), 32'h4000);
    rd(ad(1, 5), 32'h4000);
    rd(ad(0, 10), 32'h0);
    rd(12'h080, 32'h0);
    wr(12'h080, 32'h1);
    wr(ad(1, 1), 32'h1234, 4'h2);
    rd(ad(1, 1), 32'h1200);
    wr(ad(0, 2), 32'h4cf1);
    wr(ad(0, 9), 32'h32);
    for (int c = 0; c < 2; c++)
      for (int lf = 1; lf < 8; lf += 2) begin
        want[0] <= sv(Q1, Q2, Q5, Q6, c ? 100 : 0);
        wr(ad(0, 10), lf);
        repeat (3 * STEP) @(posedge aclk);
        chk(status[0].cm_high, c);
        rd(ad(0, 10), lf);
        rd(ad(0, 12), eloop(lf, c));
        rd(ad(0, 13), lf == 3 || lf == 7 ? 15 : 0);
        chk(status[0].offhook, 0);
      end
    want[0] <= sv(0, 0, 0, 0, 0);
    wr(ad(0, 10), 3);
    wr(ad(0, 1), 100);
    wr(ad(0, 2), 50);
    wr(ad(0, 3), 3);
    wr(ad(0, 15), 1);
    repeat (3 * STEP) @(posedge aclk);
    wr(ad(0, 14), 3);
    chk(irq, 0);
    want[0] <= sv(200, 0, 0, 0, 0);
    repeat (55) @(posedge aclk);
    chk(status[0].offhook, 0);
    repeat (35) @(posedge aclk);
    chk(status[0].offhook, 1);
    chk(shadow[0], 1);
    chk(irq, 1);
    chk(status[1].offhook, 0);
    rd(ad(0, 14), 1);
    want[0] <= sv(120, 0, 0, 0, 0);
    repeat (100) @(posedge aclk);
    chk(status[0].offhook, 1);
    want[0] <= sv(0, 0, 0, 0, 0);
    repeat (100) @(posedge aclk);
    chk(status[0].offhook, 0);
    wr(ad(0, 14), 3);
    wr(ad(0, 15), 0);
    want[0] <= sv(400, 0, 0, 0, 0);
    repeat (100) @(posedge aclk);
    chk(irq, 0);
    rd(ad(0, 14), 1);
    wr(ad(1, 10), 7);
    wr(ad(1, 1), 100);
    wr(ad(1, 3), 1);
    wr(ad(1, 4), 10);
    ring[1] <= 1'b1;
    repeat (3 * STEP) @(posedge aclk);
    ring[1] <= 1'b0;
    want[1] <= sv(200, 0, 0, 0, 0);
    repeat (8 * STEP) @(posedge aclk);
    chk(status[1].offhook, 0);
    repeat (7 * STEP) @(posedge aclk);
    chk(status[1].offhook, 1);
    chk(shadow[1], 5);
    rd(ad(1, 11), 32'h3);
    wr(ad(1, 6), 32'h200);
    repeat (2 * STEP) @(posedge aclk);
    chk(status[1].gkey, 1);
    wr(ad(1, 7), 32'h200);
    repeat (2 * STEP) @(posedge aclk);
    chk(status[1].gkey, 0);
    conclude();
  end
endmodule
